// ===== pkg/fcp_pkg.sv
// Constants and types shared by the flash command and protection controller
//----------------------------------------------------------------------
// Behaviour
//----------------------------------------------------------------------
// Behaviour
// - Code 01h programs the data byte at the addressed location.
// - Code 02h erases the page holding the addressed byte.
// - Code 03h erases the whole 16 kB array, needing only the key.
// - Code 04h reads the addressed byte into the data register.
// - Code 05h erases the page, then programs the byte; rest stays erased.
// - Code 08h programs protection; address and protection registers carry 32 bits.
// - Write/erase protection per page; read protection per four-page group.
// - Protection lives in the top six flash bytes, key at the lowest.
// - A bit at 1 is unprotected; cleared to 0 protects.
// - Protection acts only if the last page is read and write protected.
// - Key defaults FFh, is fixed once set, and must match to modify.
// - Key byte top bit enables the watchdog settings lock.
// - New protection takes effect only after a chip reset.
// - After activation bits only go 1 to 0; mass erase restores them.
// - Read protection does not block core table reads.
// - Byte write 30 us, page erase 20 ms, mass erase 200 ms, read 100 ns.
// - Core stalls after a command write until the operation finishes.
// - Peripheral timers keep running during the stall.
// - Download mode entered when pin low at reset; protection enforced there.
package fcp_pkg;

  //----------------------------------------------------------------------
  // Register addresses
  //----------------------------------------------------------------------
  localparam logic [7:0] ADDR_FLASH_COMMAND = 8'hB9;
  localparam logic [7:0] ADDR_PROT_KEY = 8'hBB;
  localparam logic [7:0] ADDR_ACCESS_KEY = 8'hBC;
  localparam logic [7:0] ADDR_WPROT_ZERO = 8'hBD;
  localparam logic [7:0] ADDR_WPROT_ONE = 8'hBE;
  localparam logic [7:0] ADDR_READ_PROT = 8'hBF;
  localparam logic [7:0] ADDR_FLASH_DATA = 8'hBA;
  localparam logic [7:0] ADDR_ADDR_LOW = 8'hC6;
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'hC7;

  //----------------------------------------------------------------------
  // Command codes and keys
  //----------------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h01;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
  localparam logic [7:0] CMD_READ_BYTE = 8'h04;
  localparam logic [7:0] CMD_ERASE_WRITE = 8'h05;
  localparam logic [7:0] CMD_PROTECT = 8'h08;
  localparam logic [7:0] ACCESS_KEY = 8'h3B;
  localparam logic [7:0] PROT_KEY_DEFAULT = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  //----------------------------------------------------------------------
  // Geometry
  //----------------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int PAGE_W = 5;
  localparam int OFFS_W = 9;
  localparam int DEPTH = 16384;
  localparam logic [ADDR_W-1:0] ADDR_PROT_KEY_BYTE = 14'h3FFA;
  localparam logic [ADDR_W-1:0] ADDR_READ_PROT_BYTE = 14'h3FFB;
  localparam logic [ADDR_W-1:0] ADDR_WPROT_BYTE0 = 14'h3FFC;
  localparam logic [ADDR_W-1:0] ADDR_WPROT_BYTE3 = 14'h3FFF;
  localparam logic [OFFS_W-1:0] PAGE_LAST_OFFS = 9'h1FF;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 14'h3FFF;

  //----------------------------------------------------------------------
  // Reset values
  //----------------------------------------------------------------------
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_PROT = 8'hFF;
  localparam logic [7:0] RST_DATA = 8'h00;

  //----------------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int T_WRITE_US = 30;
  localparam int T_PAGE_MS = 20;
  localparam int T_MASS_MS = 200;
  localparam int T_READ_NS = 100;
  localparam int T_PAGE_WRITE_MS = 21;
  localparam int CYC_WRITE = T_WRITE_US * CLK_MHZ;
  localparam int CYC_PAGE = T_PAGE_MS * 1000 * CLK_MHZ;
  localparam int CYC_MASS = T_MASS_MS * 1000 * CLK_MHZ;
  localparam int CYC_READ = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_PAGE_WRITE = T_PAGE_WRITE_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG = 3'b011,
    ST_BOOT = 3'b100,
    ST_DONE = 3'b101
  } fcp_state_e;

endpackage

// ===== hdl/fcp_flash_array.sv
// Flash array model memory with registered read data
`timescale 1ns/1ps
module fcp_flash_array (
  // Clock
  input wire logic sys_clk,
  // Access
  input wire logic wrEn,
  input wire logic [13:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [13:0] rdAddr,
  output logic [7:0] rdData
);

  logic [7:0] mem [0:fcp_pkg::DEPTH-1];

  // Contents are not cleared by reset: flash is non-volatile
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

// ===== hdl/fcp_flash_ctrl.sv
// Flash command sequencer with page protection
`timescale 1ns/1ps
module fcp_flash_ctrl #(
  parameter int CycWrite = fcp_pkg::CYC_WRITE,
  parameter int CycPage = fcp_pkg::CYC_PAGE,
  parameter int CycMass = fcp_pkg::CYC_MASS,
  parameter int CycPageWrite = fcp_pkg::CYC_PAGE_WRITE
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port from the core
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Core control
  output logic coreStall,
  input wire logic tableRead,
  input wire logic [13:0] tableAddr,
  output logic [7:0] tableData,
  // Pins and status
  input wire logic download_enable_pin_n,
  output logic downloadMode,
  output logic watchdogLock,
  output logic protActive
);

  //----------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------
  logic [7:0] flash_command_reg_r;
  logic [7:0] flash_data_reg_r;
  logic [7:0] flash_addr_high_reg_r;
  logic [7:0] flash_addr_low_reg_r;
  logic [7:0] flash_access_key_reg_r;
  logic [7:0] protection_key_reg_r;
  logic [7:0] wprot_byte_zero_reg_r;
  logic [7:0] wprot_byte_one_reg_r;
  logic [7:0] read_prot_reg_r;

  // Active protection image, loaded from flash after reset
  logic [31:0] wprotAct_r;
  logic [7:0] rprotAct_r;
  logic [7:0] keyAct_r;
  logic schemeOn_r;

  fcp_pkg::fcp_state_e state_r;
  logic [31:0] cnt_r;
  logic [13:0] ptr_r;
  logic [7:0] cmd_r;
  logic [2:0] bootIdx_r;
  logic [2:0] progIdx_r;
  logic padSync1_r;
  logic padSync2_r;
  logic memWe;
  logic [13:0] memWa;
  logic [7:0] memWd;
  logic [13:0] memRa;
  logic [7:0] memRd;

  //----------------------------------------------------------------------
  // Decoding
  //----------------------------------------------------------------------
  function automatic logic selReg(input logic [7:0] a, input logic [7:0] ref_a);
    selReg = (a == ref_a);
  endfunction

  wire logic [13:0] flashAddr = {flash_addr_high_reg_r[5:0], flash_addr_low_reg_r};
  wire logic [4:0] pageSel = flashAddr[13:9];
  wire logic [2:0] groupSel = pageSel[4:2];
  wire logic keyOk = (flash_access_key_reg_r == fcp_pkg::ACCESS_KEY);
  wire logic pageWprot = schemeOn_r && !wprotAct_r[pageSel];
  wire logic pageRprot = schemeOn_r && !rprotAct_r[groupSel];
  // Protection key must match whenever a non-default key is in force
  wire logic protKeyOk = (keyAct_r == fcp_pkg::PROT_KEY_DEFAULT) ||
                         (protection_key_reg_r == keyAct_r);
  wire logic cmdWr = regWr && selReg(regAddr, fcp_pkg::ADDR_FLASH_COMMAND) &&
                     (state_r == fcp_pkg::ST_IDLE);
  wire logic [31:0] protWord = {flash_addr_high_reg_r, flash_addr_low_reg_r,
                                wprot_byte_one_reg_r, wprot_byte_zero_reg_r};

  // Download mode gating; core execution may still read its own code
  wire logic rdBlocked = pageRprot && downloadMode;
  wire logic wrBlocked = pageWprot;
  wire logic cmdRead = cmdWr && regWdata == fcp_pkg::CMD_READ_BYTE;
  wire logic cmdProg = cmdWr && regWdata == fcp_pkg::CMD_WRITE_BYTE;
  wire logic cmdErPg = cmdWr && (regWdata == fcp_pkg::CMD_ERASE_PAGE ||
                                 regWdata == fcp_pkg::CMD_ERASE_WRITE);
  wire logic cmdMass = cmdWr && regWdata == fcp_pkg::CMD_ERASE_ALL;
  wire logic cmdProt = cmdWr && regWdata == fcp_pkg::CMD_PROTECT;
  wire logic okRead = cmdRead && keyOk && !rdBlocked;
  wire logic okProg = cmdProg && keyOk && !wrBlocked;
  wire logic okErPg = cmdErPg && keyOk && !wrBlocked;
  wire logic okMass = cmdMass && keyOk;
  wire logic okProt = cmdProt && keyOk && protKeyOk;

  // Bytes of the protection block, low address first: key, read, write 0..3
  wire logic [7:0] protByte [0:5];
  // Key is one-time: once non-default the stored key is written back unchanged
  assign protByte[0] = (keyAct_r == fcp_pkg::PROT_KEY_DEFAULT) ?
                       protection_key_reg_r : keyAct_r;
  assign protByte[1] = read_prot_reg_r & (schemeOn_r ? rprotAct_r : 8'hFF);
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gProt
      // Only clears can land once the scheme is active: 1 to 0 only
      assign protByte[gi+2] = schemeOn_r ? (protWord[gi*8 +: 8] & wprotAct_r[gi*8 +: 8]) :
                              protWord[gi*8 +: 8];
    end
  endgenerate

  //----------------------------------------------------------------------
  // Memory port steering
  //----------------------------------------------------------------------
  wire logic inErase = (state_r == fcp_pkg::ST_ERASE);
  wire logic inProgProt = (state_r == fcp_pkg::ST_PROG);
  wire logic lastWait = (state_r == fcp_pkg::ST_WAIT) && (cnt_r == 32'd1);
  wire logic progByte = lastWait && (cmd_r == fcp_pkg::CMD_WRITE_BYTE ||
                                     cmd_r == fcp_pkg::CMD_ERASE_WRITE);
  assign memWe = inErase || inProgProt || progByte;
  assign memWa = inProgProt ? (fcp_pkg::ADDR_PROT_KEY_BYTE + 14'(progIdx_r)) : ptr_r;
  assign memWd = inErase ? fcp_pkg::ERASED_BYTE :
                 inProgProt ? protByte[progIdx_r] : flash_data_reg_r;
  assign memRa = (state_r == fcp_pkg::ST_BOOT) ?
                 (fcp_pkg::ADDR_PROT_KEY_BYTE + 14'(bootIdx_r)) :
                 (tableRead ? tableAddr : flashAddr);

  fcp_flash_array uArray (
    .sys_clk(sys_clk),
    .wrEn(memWe),
    .wrAddr(memWa),
    .wrData(memWd),
    .rdAddr(memRa),
    .rdData(memRd)
  );

  //----------------------------------------------------------------------
  // Register writes
  //----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flash_data_reg_r <= fcp_pkg::RST_DATA;
      flash_addr_high_reg_r <= fcp_pkg::RST_ADDR;
      flash_addr_low_reg_r <= fcp_pkg::RST_ADDR;
      flash_access_key_reg_r <= fcp_pkg::RST_DATA;
      protection_key_reg_r <= fcp_pkg::PROT_KEY_DEFAULT;
      wprot_byte_zero_reg_r <= fcp_pkg::RST_PROT;
      wprot_byte_one_reg_r <= fcp_pkg::RST_PROT;
      read_prot_reg_r <= fcp_pkg::RST_PROT;
      flash_command_reg_r <= fcp_pkg::RST_DATA;
    end else begin
      if (regWr && selReg(regAddr, fcp_pkg::ADDR_FLASH_DATA)) begin
        flash_data_reg_r <= regWdata;
      end
      if (regWr && selReg(regAddr, fcp_pkg::ADDR_ADDR_HIGH)) begin
        flash_addr_high_reg_r <= regWdata;
      end
      if (regWr && selReg(regAddr, fcp_pkg::ADDR_ADDR_LOW)) begin
        flash_addr_low_reg_r <= regWdata;
      end
      if (regWr && selReg(regAddr, fcp_pkg::ADDR_PROT_KEY)) begin
        protection_key_reg_r <= regWdata;
      end
      if (regWr && selReg(regAddr, fcp_pkg::ADDR_WPROT_ZERO)) begin
        wprot_byte_zero_reg_r <= regWdata;
      end
      if (regWr && selReg(regAddr, fcp_pkg::ADDR_WPROT_ONE)) begin
        wprot_byte_one_reg_r <= regWdata;
      end
      if (regWr && selReg(regAddr, fcp_pkg::ADDR_READ_PROT)) begin
        read_prot_reg_r <= regWdata;
      end
      // Key is consumed by each command so every command needs a fresh key
      if (cmdWr) begin
        flash_access_key_reg_r <= fcp_pkg::RST_DATA;
        flash_command_reg_r <= regWdata;
      end else if (regWr && selReg(regAddr, fcp_pkg::ADDR_ACCESS_KEY)) begin
        flash_access_key_reg_r <= regWdata;
      end
      if (state_r == fcp_pkg::ST_DONE && cmd_r == fcp_pkg::CMD_READ_BYTE) begin
        flash_data_reg_r <= memRd;
      end
    end
  end

  //----------------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= fcp_pkg::ST_BOOT;
      cnt_r <= 32'd0;
      ptr_r <= 14'h0000;
      cmd_r <= 8'h00;
      bootIdx_r <= 3'd0;
      progIdx_r <= 3'd0;
    end else begin
      case (state_r)
        fcp_pkg::ST_BOOT: begin
          bootIdx_r <= bootIdx_r + 3'd1;
          if (bootIdx_r == 3'd6) begin
            state_r <= fcp_pkg::ST_IDLE;
          end
        end
        fcp_pkg::ST_IDLE: begin
          cmd_r <= 8'h00;
          ptr_r <= flashAddr;
          if (okRead) begin
            cmd_r <= regWdata;
            cnt_r <= 32'(fcp_pkg::CYC_READ);
            state_r <= fcp_pkg::ST_WAIT;
          end else if (okProg) begin
            cmd_r <= regWdata;
            cnt_r <= 32'(CycWrite);
            state_r <= fcp_pkg::ST_WAIT;
          end else if (okErPg) begin
            cmd_r <= regWdata;
            ptr_r <= {pageSel, 9'h000};
            cnt_r <= (regWdata == fcp_pkg::CMD_ERASE_WRITE) ? 32'(CycPageWrite) :
                     32'(CycPage);
            state_r <= fcp_pkg::ST_ERASE;
          end else if (okMass) begin
            cmd_r <= regWdata;
            ptr_r <= 14'h0000;
            cnt_r <= 32'(CycMass);
            state_r <= fcp_pkg::ST_ERASE;
          end else if (okProt) begin
            cmd_r <= regWdata;
            progIdx_r <= 3'd0;
            cnt_r <= 32'(CycWrite);
            state_r <= fcp_pkg::ST_PROG;
          end else if (cmdWr) begin
            // Refused commands still pass through a one-cycle completion
            state_r <= fcp_pkg::ST_DONE;
          end
        end
        fcp_pkg::ST_ERASE: begin
          // One byte erased per cycle; remaining time is spent in the wait
          cnt_r <= cnt_r - 32'd1;
          if ((cmd_r == fcp_pkg::CMD_ERASE_ALL && ptr_r == fcp_pkg::ADDR_LAST) ||
              (cmd_r != fcp_pkg::CMD_ERASE_ALL &&
               ptr_r[8:0] == fcp_pkg::PAGE_LAST_OFFS)) begin
            ptr_r <= flashAddr;
            state_r <= fcp_pkg::ST_WAIT;
          end else begin
            ptr_r <= ptr_r + 14'd1;
          end
        end
        fcp_pkg::ST_PROG: begin
          progIdx_r <= progIdx_r + 3'd1;
          if (progIdx_r == 3'd5) begin
            state_r <= fcp_pkg::ST_WAIT;
          end
        end
        fcp_pkg::ST_WAIT: begin
          if (cnt_r <= 32'd1) begin
            state_r <= fcp_pkg::ST_DONE;
          end else begin
            cnt_r <= cnt_r - 32'd1;
          end
        end
        fcp_pkg::ST_DONE: begin
          state_r <= fcp_pkg::ST_IDLE;
        end
        default: begin
          state_r <= fcp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  //----------------------------------------------------------------------
  // Protection image and download strap, captured after reset
  //----------------------------------------------------------------------
  // Read data lag the address by one cycle, so capture uses bootIdx_r - 1
  wire logic [2:0] bootCap = bootIdx_r - 3'd1;
  always_ff @(posedge sys_clk) begin
    padSync1_r <= download_enable_pin_n;
    padSync2_r <= padSync1_r;
    if (srst) begin
      wprotAct_r <= 32'hFFFF_FFFF;
      rprotAct_r <= fcp_pkg::RST_PROT;
      keyAct_r <= fcp_pkg::PROT_KEY_DEFAULT;
      schemeOn_r <= 1'b0;
      downloadMode <= 1'b0;
    end else if (state_r == fcp_pkg::ST_BOOT) begin
      // New settings only load here, so they only act after a reset
      if (bootIdx_r != 3'd0) begin
        case (bootCap)
          3'd0: keyAct_r <= memRd;
          3'd1: rprotAct_r <= memRd;
          3'd2: wprotAct_r[7:0] <= memRd;
          3'd3: wprotAct_r[15:8] <= memRd;
          3'd4: wprotAct_r[23:16] <= memRd;
          3'd5: wprotAct_r[31:24] <= memRd;
          default: wprotAct_r <= wprotAct_r;
        endcase
      end
      if (bootIdx_r == 3'd6) begin
        schemeOn_r <= !memRd[7] && !rprotAct_r[7];
        downloadMode <= !padSync2_r;
      end
    end
  end

  //----------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------
  // Only the core stalls; peripherals outside keep their own clock running
  assign coreStall = (state_r != fcp_pkg::ST_IDLE);
  assign watchdogLock = !keyAct_r[7];
  assign protActive = schemeOn_r;
  // Table reads come straight from the array and ignore read protection
  assign tableData = memRd;

  wire logic [7:0] rdMux =
    selReg(regAddr, fcp_pkg::ADDR_FLASH_COMMAND) ? flash_command_reg_r :
    selReg(regAddr, fcp_pkg::ADDR_FLASH_DATA) ? flash_data_reg_r :
    selReg(regAddr, fcp_pkg::ADDR_ADDR_HIGH) ? flash_addr_high_reg_r :
    selReg(regAddr, fcp_pkg::ADDR_ADDR_LOW) ? flash_addr_low_reg_r :
    selReg(regAddr, fcp_pkg::ADDR_READ_PROT) ? read_prot_reg_r :
    selReg(regAddr, fcp_pkg::ADDR_WPROT_ONE) ? wprot_byte_one_reg_r :
    selReg(regAddr, fcp_pkg::ADDR_WPROT_ZERO) ? wprot_byte_zero_reg_r : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= rdMux;
    end
  end

endmodule

// ===== verif/fcp_core_model.sv
// Core-side model issuing register accesses, commands and table reads
`timescale 1ns/1ps
module fcp_core_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic regWr,
  output logic regRd,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic coreStall,
  // Table reads
  output logic tableRead,
  output logic [13:0] tableAddr,
  input wire logic [7:0] tableData
);
  logic [7:0] r0 = 8'h00;
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    tableRead = 1'b0;
    tableAddr = 14'h0000;
  end
  // Released lines show the inverse so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(negedge sys_clk);
    regWr = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge sys_clk);
    regRd = 1'b0;
    regAddr = ~a;
    d = regRdata;
  endtask
  task automatic tread(input logic [13:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    tableRead = 1'b1;
    tableAddr = a;
    @(negedge sys_clk);
    d = tableData;
    tableRead = 1'b0;
    tableAddr = ~a;
  endtask
  task automatic idle(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 20000 && !ok; i++) begin
      @(negedge sys_clk);
      ok = (coreStall === 1'b0);
    end
  endtask
  task automatic cmd(input logic [7:0] c, output bit ok);
    wr(8'hBC, 8'h3B);
    wr(8'hB9, c);
    idle(ok);
  endtask
  task automatic emu(input logic [7:0] code, input logic [7:0] d);
    if (code == 8'h49) begin
      r0 = d;
    end else if (code == 8'h46) begin
      wr(d, r0);
    end
  endtask
endmodule

// ===== verif/fcp_flash_ctrl_chk.sv
// Port-level checks on the flash command and protection controller
`timescale 1ns/1ps
module fcp_flash_ctrl_chk #(
  parameter int CycWrite = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port and status
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic coreStall,
  input wire logic downloadMode,
  input wire logic watchdogLock,
  input wire logic protActive
);
  localparam int WrMax = CycWrite + 8;
  logic keyOk_r;
  wire logic cmdGo;
  wire logic mapped;
  assign cmdGo = regWr && regAddr == 8'hB9 && !coreStall;
  assign mapped = regAddr inside {8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC6, 8'hC7};
  // Key arms one command only; a command write made while the core is not stalled disarms it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      keyOk_r <= 1'b0;
    end else if (regWr && regAddr == 8'hBC) begin
      keyOk_r <= regWdata == 8'h3B;
    end else if (cmdGo) begin
      keyOk_r <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rst;
    disable iff (1'b0) srst |=> coreStall && !downloadMode && !protActive && regRdata == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_boot;
    $fell(srst) |-> coreStall [*4];
  endproperty
  a_boot: assert property (p_boot) else $error("boot stall short");
  property p_stall;
    cmdGo |=> coreStall;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall on command");
  property p_rdtime;
    cmdGo && regWdata == 8'h04 && keyOk_r && !downloadMode |=> coreStall [*8] ##[1:40] !coreStall;
  endproperty
  a_rdtime: assert property (p_rdtime) else $error("read time wrong");
  property p_wrtime;
    cmdGo && regWdata == 8'h01 && keyOk_r && !protActive |=> coreStall [*8] ##[1:WrMax] !coreStall;
  endproperty
  a_wrtime: assert property (p_wrtime) else $error("write time wrong");
  property p_nokey;
    cmdGo && !keyOk_r |=> coreStall ##1 !coreStall;
  endproperty
  a_nokey: assert property (p_nokey) else $error("unkeyed command ran");
  property p_keyhide;
    regRd && (regAddr == 8'hBB || regAddr == 8'hBC) |=> regRdata == 8'h00;
  endproperty
  a_keyhide: assert property (p_keyhide) else $error("key readable");
  property p_unmap;
    regRd && !mapped |=> regRdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_protheld;
    !coreStall && $past(coreStall) == 1'b0 |-> $stable(protActive) && $stable(watchdogLock);
  endproperty
  a_protheld: assert property (p_protheld) else $error("protection changed");
  property p_dlheld;
    !coreStall && $past(coreStall) == 1'b0 |-> $stable(downloadMode);
  endproperty
  a_dlheld: assert property (p_dlheld) else $error("mode changed");
endmodule
bind fcp_flash_ctrl fcp_flash_ctrl_chk #(.CycWrite(CycWrite)) i_chk (
  .sys_clk(sys_clk), .srst(srst), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .coreStall(coreStall),
  .downloadMode(downloadMode), .watchdogLock(watchdogLock), .protActive(protActive));

// ===== verif/fcp_flash_ctrl_tb.sv
// Self-checking bench for the flash command and protection controller
`timescale 1ns/1ps
module fcp_flash_ctrl_tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic dlPin_n = 1'b1;
  wire logic regWr, regRd, tableRead, coreStall, downloadMode, watchdogLock, protActive;
  wire logic [7:0] regAddr, regWdata, regRdata, tableData;
  wire logic [13:0] tableAddr;
  int num_errors = 0;
  int n_compared = 0;
  always #2 sys_clk = ~sys_clk;
  initial for (int i = 0; i < 16384; i++) i_dut.uArray.mem[i] = 8'h00;
  // Short erase and write counts keep the run small
  fcp_flash_ctrl #(.CycWrite(20), .CycPage(600), .CycMass(17000), .CycPageWrite(600)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .coreStall(coreStall), .tableRead(tableRead),
    .tableAddr(tableAddr), .tableData(tableData), .download_enable_pin_n(dlPin_n),
    .downloadMode(downloadMode), .watchdogLock(watchdogLock), .protActive(protActive));
  fcp_core_model i_core (
    .sys_clk(sys_clk), .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .coreStall(coreStall), .tableRead(tableRead), .tableAddr(tableAddr),
    .tableData(tableData));
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input logic [7:0] c, input bit send);
    bit ok;
    if (send) i_core.cmd(c, ok);
    else i_core.idle(ok);
    if (!ok) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic do_reset(input logic pin);
    @(negedge sys_clk);
    srst = 1'b1;
    dlPin_n = pin;
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    run(8'h00, 1'b0);
  endtask
  task automatic tq(input string nm, input logic [13:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_core.tread(a, v);
    chk(nm, exp, v);
  endtask
  task automatic put(input logic [13:0] a, input logic [7:0] d, input logic [7:0] c);
    i_core.wr(8'hC7, {2'b00, a[13:8]});
    i_core.wr(8'hC6, a[7:0]);
    i_core.wr(8'hBA, d);
    run(c, 1'b1);
  endtask
  task automatic prot(input logic [7:0] hi, input logic [7:0] rp, input logic [7:0] key);
    i_core.wr(8'hBD, 8'hFF);
    i_core.wr(8'hBE, 8'hFF);
    i_core.wr(8'hC6, 8'hFF);
    i_core.wr(8'hC7, hi);
    i_core.wr(8'hBF, rp);
    i_core.wr(8'hBB, key);
    run(8'h08, 1'b1);
  endtask
  //----------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------
  task automatic t_mass();
    run(8'h03, 1'b1);
    tq("low byte", 14'h0000, 8'hFF);
    tq("top byte", 14'h3FFF, 8'hFF);
    do_reset(1'b1);
    chk("protActive", 8'h00, {7'h00, protActive});
    chk("watchdogLock", 8'h00, {7'h00, watchdogLock});
    chk("downloadMode", 8'h00, {7'h00, downloadMode});
  endtask
  task automatic t_rw();
    logic [7:0] v;
    put(14'h3C00, 8'hF3, 8'h01);
    put(14'h3C00, 8'h00, 8'h04);
    i_core.rd(8'hBA, v);
    chk("read byte", 8'hF3, v);
    tq("table read", 14'h3C00, 8'hF3);
    i_core.wr(8'hBA, 8'h00);
    i_core.wr(8'hB9, 8'h01);
    run(8'h00, 1'b0);
    tq("unkeyed write", 14'h3C00, 8'hF3);
    i_core.rd(8'hBC, v);
    chk("access key read", 8'h00, v);
    i_core.rd(8'h80, v);
    chk("unmapped read", 8'h00, v);
  endtask
  task automatic t_page();
    put(14'h3E00, 8'h66, 8'h01);
    put(14'h3C01, 8'h12, 8'h01);
    put(14'h3C00, 8'hA5, 8'h05);
    tq("erase-write byte", 14'h3C00, 8'hA5);
    tq("erase-write rest", 14'h3C01, 8'hFF);
    put(14'h3C00, 8'h00, 8'h02);
    tq("page erased", 14'h3C00, 8'hFF);
    tq("next page kept", 14'h3E00, 8'h66);
  endtask
  task automatic t_prot();
    prot(8'h7F, 8'h7F, 8'h23);
    chk("protActive early", 8'h00, {7'h00, protActive});
    tq("key byte", 14'h3FFA, 8'h23);
    tq("read byte", 14'h3FFB, 8'h7F);
    tq("wprot top", 14'h3FFF, 8'h7F);
    tq("wprot low", 14'h3FFE, 8'hFF);
    do_reset(1'b1);
    chk("protActive", 8'h01, {7'h00, protActive});
    chk("watchdogLock", 8'h01, {7'h00, watchdogLock});
    put(14'h3E00, 8'h00, 8'h01);
    tq("protected page", 14'h3E00, 8'h66);
    put(14'h0000, 8'h3C, 8'h01);
    tq("open page", 14'h0000, 8'h3C);
    prot(8'hFF, 8'hFF, 8'h23);
    tq("no revert", 14'h3FFF, 8'h7F);
    tq("no revert read", 14'h3FFB, 8'h7F);
    prot(8'h7F, 8'h7F, 8'h55);
    tq("key fixed", 14'h3FFA, 8'h23);
  endtask
  task automatic t_dl();
    logic [7:0] v;
    do_reset(1'b0);
    chk("downloadMode", 8'h01, {7'h00, downloadMode});
    i_core.emu(8'h49, 8'h3E);
    i_core.emu(8'h46, 8'hC7);
    i_core.emu(8'h49, 8'h00);
    i_core.emu(8'h46, 8'hC6);
    i_core.emu(8'h49, 8'h5A);
    i_core.emu(8'h46, 8'hBA);
    run(8'h04, 1'b1);
    i_core.rd(8'hBA, v);
    chk("hidden read", 8'h5A, v);
  endtask
  task automatic t_unlock();
    run(8'h03, 1'b1);
    do_reset(1'b1);
    chk("protActive", 8'h00, {7'h00, protActive});
    tq("bits restored", 14'h3FFF, 8'hFF);
  endtask
  initial begin
    do_reset(1'b1);
    t_mass();
    t_rw();
    t_page();
    t_prot();
    t_dl();
    t_unlock();
    report_and_stop();
  end
endmodule
